// ==== inc/ecf_pkg.sv ====
`default_nettype none
package ecf_pkg;
    // Fan strategy codes
    localparam logic [7:0] FAN_TYPE_DUAL = 8'h06;
    localparam logic [7:0] FAN_TYPE_SINGLE = 8'h07;
    localparam logic [7:0] FAN_TYPE_NONE = 8'hFF;
    // Third switched output function codes
    localparam logic [7:0] SW_FUNC_NONE = 8'h00;
    localparam logic [7:0] SW_FUNC_FAN = 8'h11;
    // AC status input modes
    localparam logic [2:0] AC_MODE_OFF = 3'h0;
    localparam logic [2:0] AC_MODE_CLOSED = 3'h1;
    localparam logic [2:0] AC_MODE_OPEN = 3'h2;
    localparam logic [2:0] LIMIT_MODE_CLOSED = 3'h3;
    localparam logic [2:0] LIMIT_MODE_OPEN = 3'h4;

    // Register byte offsets
    localparam logic [7:0] REG_CFG_OFS = 8'h00;
    localparam logic [7:0] REG_SPEED_OFS = 8'h04;
    localparam logic [7:0] REG_HOLD_OFS = 8'h08;
    localparam logic [7:0] REG_STATUS_OFS = 8'h0C;

    // Field positions
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_SW_LSB = 8;
    localparam int CFG_ACMODE_LSB = 16;
    localparam int CFG_ACSPDEN_BIT = 24;
    localparam int CFG_PTOEN_BIT = 25;
    localparam int CFG_ACAUTO_BIT = 26;
    localparam int CFG_NETEN_BIT = 27;
    localparam int CFG_FANSPDEN_BIT = 28;
    localparam int CFG_BRAKEEN_BIT = 29;
    localparam int SPD_AC_LSB = 0;
    localparam int SPD_FAN_LSB = 8;
    localparam int HOLD_FAN_LSB = 0;
    localparam int HOLD_AC_LSB = 16;

    // Values after reset
    localparam logic [2:0] AC_MODE_RST = AC_MODE_OPEN;
    localparam logic [7:0] AC_SPEED_RST = 8'h20;
    localparam logic [7:0] FAN_SPEED_RST = 8'h00;
    localparam logic [9:0] HOLD_FAN_RST = 10'h00A;
    localparam logic [9:0] HOLD_AC_RST = 10'h0B4;
    localparam logic ACAUTO_RST = 1'b1;

    // Time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [9:0] MIN_RUN_S = 10'h01E;
    localparam logic [2:0] START_DELAY_S = 3'h5;
endpackage : ecf_pkg
`default_nettype wire

// ==== hw/ecf_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecf_pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    // A change counts only once stages two and three agree
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pinOut = out_reg;
endmodule : ecf_pin_sync
`default_nettype wire

// ==== hw/ecf_hold_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecf_hold_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic demand,
    input wire logic [9:0] holdSecs,
    output logic fanOn,
    output logic [9:0] secsOn
);
    logic on_reg;
    logic on_next;
    logic [9:0] secs_reg;
    logic [9:0] secs_next;

    always_comb begin
        on_next = on_reg;
        secs_next = secs_reg;
        if (!enable) begin
            on_next = 1'b0;
            secs_next = '0;
        end else if (!on_reg) begin
            on_next = demand;
            secs_next = '0;
        end else if (!demand && secs_reg >= holdSecs) begin
            on_next = 1'b0;
        end else if (tick && secs_reg != 10'h3FF) begin
            // Saturates so a long run never wraps under the hold limit
            secs_next = secs_reg + 10'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_reg <= 1'b0;
            secs_reg <= '0;
        end else begin
            on_reg <= on_next;
            secs_reg <= secs_next;
        end
    end

    assign fanOn = on_reg;
    assign secsOn = secs_reg;
endmodule : ecf_hold_timer
`default_nettype wire

// ==== hw/ecf_fan_ctrl.sv ====
// Contract
// [RQ1] Fan type 7 single output, 6 dual fans, 255 no fan control.
// [RQ2] Third switched output drives the fan only with function code 17.
// [RQ3] AC speed feature above threshold drops the AC minimum hold time.
// [RQ4] Fan speed feature ignores fan requests below the fan speed threshold.
// [RQ5] AC status input read per mode code 0 to 4, default 2.
// [RQ6] Power takeoff auto activation turns on fan 1, and fan 2 when dual.
// [RQ7] AC auto activation turns on fan 1 only, never fan 2.
// [RQ8] Dual mode has two outputs, open means on, each its own conditions.
// [RQ9] A fan once on runs at least 30 seconds.
// [RQ10] All fan outputs off until five seconds after engine start.
// [RQ11] Dual mode: override or engine brake turns on both fans.
// [RQ12] Fan 1 on for temperature, sensor fault, AC, brake, override, takeoff.
// [RQ13] Fan 2 on for temperature, brake, override, takeoff.
// [RQ14] Failed temperature sensor turns on both fans.
// [RQ15] Configured engine brake activation turns fans on at high brake level.
// [RQ16] Vehicle side grounds the override input to force fans on.
// [RQ17] General minimum on time default 10 s, AC minimum on time 180 s.
// [RQ18] Network fan request acts only when its enable is set.
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ecf_fan_ctrl #(
    parameter int TICK_CYCLES = ecf_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic engineRunning,
    input wire logic acSwitchOpen,
    input wire logic overrideHigh_n,
    input wire logic brakeHigh,
    input wire logic powerTakeoffActive,
    input wire logic tempOverLimit,
    input wire logic tempSensorFault,
    input wire logic netFanRequest,
    input wire logic [7:0] roadSpeed,
    output logic fanCtl1Open,
    output logic fanCtl2Open,
    output logic thirdSwitchedOutputOpen
);
    logic [31:0] cfg_reg, cfg_next;
    logic [31:0] spd_reg, spd_next;
    logic [31:0] hold_reg, hold_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wrPend_reg, wrPend_next;
    logic [7:0] wrAddr_reg, wrAddr_next;
    logic [31:0] tickCnt_reg, tickCnt_next;
    logic tick_reg, tick_next;
    logic [2:0] startCnt_reg, startCnt_next;
    logic acArm_reg, acArm_next;
    logic [4:0] pins;
    logic engOn, acOpen, ovrGnd, brkHi, takeoffOn;
    logic [7:0] fanType, swFunc, acThr, fanThr;
    logic [2:0] acMode;
    logic [9:0] holdFan, holdAc, hold1, hold2, secs1, secs2;
    logic startDone, isDual, isSingle, en1, en2, speedBlock, acSkip;
    logic acActive, limitActive, acReq, brakeReq, takeoffReq, netReq, common;
    logic dem1, dem2, fan1, fan2;
    logic addrPhase;

    function automatic logic [9:0] max10(input logic [9:0] a, input logic [9:0] b);
        max10 = (a > b) ? a : b;
    endfunction : max10

    ecf_pin_sync #(.WIDTH(5)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn({engineRunning, acSwitchOpen, overrideHigh_n, brakeHigh, powerTakeoffActive}),
        .pinOut(pins)
    );
    assign {engOn, acOpen} = pins[4:3];
    assign ovrGnd = ~pins[2]; // RQ16
    assign brkHi = pins[1];
    assign takeoffOn = pins[0];

    assign fanType = cfg_reg[ecf_pkg::CFG_TYPE_LSB +: 8];
    assign swFunc = cfg_reg[ecf_pkg::CFG_SW_LSB +: 8];
    assign acMode = cfg_reg[ecf_pkg::CFG_ACMODE_LSB +: 3];
    assign acThr = spd_reg[ecf_pkg::SPD_AC_LSB +: 8];
    assign fanThr = spd_reg[ecf_pkg::SPD_FAN_LSB +: 8];
    assign holdFan = hold_reg[ecf_pkg::HOLD_FAN_LSB +: 10];
    assign holdAc = hold_reg[ecf_pkg::HOLD_AC_LSB +: 10];

    // Bus slave: zero wait states, write data lands one cycle after its address
    assign addrPhase = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    always_comb begin
        cfg_next = cfg_reg;
        spd_next = spd_reg;
        hold_next = hold_reg;
        wrPend_next = addrPhase && hwrite;
        wrAddr_next = addrPhase ? haddr[7:0] : wrAddr_reg;
        if (wrPend_reg) begin
            unique case (wrAddr_reg)
                ecf_pkg::REG_CFG_OFS: cfg_next = hwdata & 32'h3F07_FFFF;
                ecf_pkg::REG_SPEED_OFS: spd_next = hwdata & 32'h0000_FFFF;
                ecf_pkg::REG_HOLD_OFS: hold_next = hwdata & 32'h03FF_03FF;
                default: ;
            endcase
        end
        rdata_next = rdata_reg;
        // Reads see the value as updated by a write in its data phase
        if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                ecf_pkg::REG_CFG_OFS: rdata_next = cfg_next;
                ecf_pkg::REG_SPEED_OFS: rdata_next = spd_next;
                ecf_pkg::REG_HOLD_OFS: rdata_next = hold_next;
                ecf_pkg::REG_STATUS_OFS: rdata_next = {20'h0_0000, limitActive, acActive,
                    startDone, acArm_reg, pins, thirdSwitchedOutputOpen, fan2, fan1};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // One second time base and start delay
    always_comb begin
        tick_next = 1'b0;
        tickCnt_next = tickCnt_reg + 32'h0000_0001;
        if (tickCnt_reg >= 32'(TICK_CYCLES - 1)) begin
            tickCnt_next = 32'h0000_0000;
            tick_next = 1'b1;
        end
        startCnt_next = startCnt_reg;
        if (!engOn) begin
            startCnt_next = 3'h0;
        end else if (tick_reg && !startDone) begin
            startCnt_next = startCnt_reg + 3'h1;
        end
    end
    assign startDone = (startCnt_reg == ecf_pkg::START_DELAY_S); // RQ10

    // Strategy and enables
    assign isDual = (fanType == ecf_pkg::FAN_TYPE_DUAL); // RQ1 RQ8
    assign isSingle = (fanType == ecf_pkg::FAN_TYPE_SINGLE); // RQ1
    assign en1 = startDone && (isDual || isSingle); // RQ10
    assign en2 = startDone && isDual; // RQ10

    // AC switch interpretation; limit modes never request the fan
    always_comb begin
        acActive = 1'b0;
        limitActive = 1'b0;
        unique case (acMode) // RQ5
            ecf_pkg::AC_MODE_CLOSED: acActive = ~acOpen;
            ecf_pkg::AC_MODE_OPEN: acActive = acOpen;
            ecf_pkg::LIMIT_MODE_CLOSED: limitActive = ~acOpen;
            ecf_pkg::LIMIT_MODE_OPEN: limitActive = acOpen;
            default: ;
        endcase
    end

    assign speedBlock = cfg_reg[ecf_pkg::CFG_FANSPDEN_BIT] && (roadSpeed < fanThr); // RQ4
    assign acSkip = cfg_reg[ecf_pkg::CFG_ACSPDEN_BIT] && (roadSpeed > acThr); // RQ3
    assign acReq = cfg_reg[ecf_pkg::CFG_ACAUTO_BIT] && acActive; // RQ7
    assign brakeReq = cfg_reg[ecf_pkg::CFG_BRAKEEN_BIT] && brkHi; // RQ15
    assign takeoffReq = cfg_reg[ecf_pkg::CFG_PTOEN_BIT] && takeoffOn; // RQ6
    assign netReq = cfg_reg[ecf_pkg::CFG_NETEN_BIT] && netFanRequest; // RQ18
    // Conditions shared by both outputs
    assign common = tempOverLimit || tempSensorFault || brakeReq || ovrGnd || takeoffReq; // RQ14 RQ11
    assign dem1 = !speedBlock && (common || acReq || netReq); // RQ12
    assign dem2 = !speedBlock && common; // RQ13 RQ7

    // Hold: fixed 30 s floor, general hold, AC hold unless road speed skips it
    assign hold2 = max10(ecf_pkg::MIN_RUN_S, holdFan); // RQ9 RQ17
    assign hold1 = acArm_reg ? max10(hold2, holdAc) : hold2; // RQ17 RQ3

    always_comb begin
        acArm_next = acArm_reg;
        if (!fan1 && !dem1) begin
            acArm_next = 1'b0;
        end else if (acReq && !acSkip && dem1) begin
            acArm_next = 1'b1;
        end
    end

    ecf_hold_timer u_fan1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick_reg),
        .enable(en1),
        .demand(dem1),
        .holdSecs(hold1),
        .fanOn(fan1),
        .secsOn(secs1)
    );

    ecf_hold_timer u_fan2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(tick_reg),
        .enable(en2),
        .demand(dem2),
        .holdSecs(hold2),
        .fanOn(fan2),
        .secsOn(secs2)
    );

    // High output means the sink is released, fan on
    assign fanCtl1Open = fan1; // RQ8
    assign fanCtl2Open = fan2; // RQ8
    assign thirdSwitchedOutputOpen = (swFunc == ecf_pkg::SW_FUNC_FAN) && fan1; // RQ2

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= {2'b00, 1'b0, 1'b0, 1'b0, ecf_pkg::ACAUTO_RST, 1'b0, 1'b0,
                5'h00, ecf_pkg::AC_MODE_RST, ecf_pkg::SW_FUNC_NONE, ecf_pkg::FAN_TYPE_NONE};
            spd_reg <= {16'h0000, ecf_pkg::FAN_SPEED_RST, ecf_pkg::AC_SPEED_RST};
            hold_reg <= {6'h00, ecf_pkg::HOLD_AC_RST, 6'h00, ecf_pkg::HOLD_FAN_RST};
            rdata_reg <= 32'h0000_0000;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            tickCnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
            startCnt_reg <= 3'h0;
            acArm_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            spd_reg <= spd_next;
            hold_reg <= hold_next;
            rdata_reg <= rdata_next;
            wrPend_reg <= wrPend_next;
            wrAddr_reg <= wrAddr_next;
            tickCnt_reg <= tickCnt_next;
            tick_reg <= tick_next;
            startCnt_reg <= startCnt_next;
            acArm_reg <= acArm_next;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Registered fan outputs lag a dropped enable by one cycle
    start_gate_a: assert property (!startDone |=> !fan1 && !fan2) // RQ10
        else $error("fan output on before start delay");
    type_none_a: assert property (fanType == ecf_pkg::FAN_TYPE_NONE |=> !fan1 && !fan2) // RQ1
        else $error("fan on with no fan type");
    single_one_a: assert property (!isDual |=> !fan2) // RQ1
        else $error("second fan on outside dual mode");
    sw_func_a: assert property (swFunc != ecf_pkg::SW_FUNC_FAN |-> !thirdSwitchedOutputOpen) // RQ2
        else $error("third output active without fan function");
    both_force_a: assert property (en2 && en1 && !speedBlock && (ovrGnd || brakeReq) // RQ11
        ##1 en2 && en1 |-> fan1 && fan2)
        else $error("override or brake did not start both fans");
    sensor_both_a: assert property (en2 && en1 && !speedBlock && tempSensorFault // RQ14
        ##1 en2 && en1 |-> fan1 && fan2)
        else $error("sensor fault did not start both fans");
    takeoff_fans_a: assert property (en1 && !speedBlock && takeoffReq ##1 en1 // RQ6
        |-> fan1 && (fan2 || !en2))
        else $error("takeoff did not start fans");
    speed_gate_a: assert property (en1 && speedBlock && !fan1 |=> !fan1) // RQ4
        else $error("fan started below speed threshold");
    ac_fan2_a: assert property (!fan2 && !dem2 |=> !fan2) // RQ7
        else $error("second fan started without its conditions");
    min_run_a: assert property ($fell(fan2) && en2 |-> $past(secs2) >= ecf_pkg::MIN_RUN_S) // RQ9
        else $error("second fan stopped before minimum run");
    hold_one_a: assert property ($fell(fan1) && en1 |-> $past(secs1) >= $past(hold1)) // RQ17
        else $error("first fan stopped before its hold time");
    ac_mode_a: assert property (acMode == ecf_pkg::AC_MODE_OFF |-> !acActive && !limitActive) // RQ5
        else $error("AC input active while disabled");
    net_gate_a: assert property (!cfg_reg[ecf_pkg::CFG_NETEN_BIT] && !fan1 && !common // RQ18
        && !acReq |=> !fan1)
        else $error("network request used while disabled");
    fan1_start_a: assert property (en1 && dem1 && !fan1 |=> fan1) // RQ12
        else $error("first fan ignored its demand");
    fan2_start_a: assert property (en2 && dem2 && !fan2 |=> fan2) // RQ13
        else $error("second fan ignored its demand");
    speed_gate2_a: assert property (en2 && speedBlock && !fan2 |=> !fan2) // RQ4
        else $error("second fan started below speed threshold");
    third_mirror_a: assert property (swFunc == ecf_pkg::SW_FUNC_FAN // RQ2
        |-> thirdSwitchedOutputOpen == fan1)
        else $error("third output does not follow the first fan");
    ac_skip_a: assert property (acSkip && !acArm_reg |=> !acArm_reg) // RQ3
        else $error("AC hold armed above speed threshold");
    ac_hold_a: assert property ($fell(fan1) && en1 && $past(acArm_reg) // RQ17
        |-> $past(secs1) >= $past(holdAc))
        else $error("first fan stopped before the AC hold time");
    start_reset_a: assert property (!engOn |=> !startDone) // RQ10
        else $error("start delay not restarted by engine stop");
    tick_wrap_a: assert property (tick_reg |-> tickCnt_reg == 32'h0000_0000) // RQ9
        else $error("second tick out of step with its counter");
    hold_write_a: assert property (wrPend_reg && wrAddr_reg == ecf_pkg::REG_HOLD_OFS // RQ17
        |=> holdFan == $past(hwdata[9:0]))
        else $error("general hold time write did not land");

    dual_both_c: cover property (isDual && fan1 && fan2);
    ac_fan1_c: cover property (acReq && fan1 && !fan2);
    ac_skip_c: cover property (acSkip && fan1);
    fan_stop_c: cover property ($fell(fan1));
    net_fan1_c: cover property (netReq && fan1 && !fan2);
endmodule : ecf_fan_ctrl
`default_nettype wire

// ==== bench/ecf_vehicle_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecf_vehicle_model (
    input wire logic wantEngine,
    input wire logic wantAc,
    input wire logic acOpenWhenOn,
    input wire logic wantOverride,
    input wire logic wantBrake,
    input wire logic wantTakeoff,
    input wire logic fanCtl1Open,
    input wire logic fanCtl2Open,
    output logic engineRunning,
    output logic acSwitchOpen,
    output logic overrideHigh_n,
    output logic brakeHigh,
    output logic powerTakeoffActive,
    output logic fan1Spinning,
    output logic fan2Spinning
);
    assign engineRunning = wantEngine;
    // Idle contact rests at the inactive level of the chosen sense
    assign acSwitchOpen = wantAc ? acOpenWhenOn : !acOpenWhenOn;
    assign overrideHigh_n = !wantOverride;
    assign brakeHigh = wantBrake;
    assign powerTakeoffActive = wantTakeoff;
    // Released output drops the relay out, so the fan engages
    assign fan1Spinning = fanCtl1Open;
    assign fan2Spinning = fanCtl2Open;
endmodule : ecf_vehicle_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TICK = 10;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp;
    logic [7:0] roadSpeed = 8'h00;
    logic [6:0] cond = 7'h00;
    logic engineOn = 1'b0;
    logic acOpenWhenOn = 1'b1;
    logic thirdOn = 1'b1;
    logic engineRunning, acSwitchOpen, overrideHigh_n, brakeHigh, powerTakeoffActive;
    logic fanCtl1Open, fanCtl2Open, thirdSwitchedOutputOpen, fan1Spinning, fan2Spinning;
    int fails = 0;
    int nCompared = 0;
    int h, g, k, n, m, i, thrA, thrF;

    always #50 clk_sys = ~clk_sys;

    ecf_vehicle_model u_vehicle (
        .wantEngine(engineOn), .wantAc(cond[2]), .acOpenWhenOn(acOpenWhenOn),
        .wantOverride(cond[4]), .wantBrake(cond[3]), .wantTakeoff(cond[5]),
        .fanCtl1Open(fanCtl1Open), .fanCtl2Open(fanCtl2Open),
        .engineRunning(engineRunning), .acSwitchOpen(acSwitchOpen),
        .overrideHigh_n(overrideHigh_n), .brakeHigh(brakeHigh),
        .powerTakeoffActive(powerTakeoffActive), .fan1Spinning(fan1Spinning),
        .fan2Spinning(fan2Spinning)
    );

    ecf_fan_ctrl #(.TICK_CYCLES(TICK)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .engineRunning(engineRunning), .acSwitchOpen(acSwitchOpen),
        .overrideHigh_n(overrideHigh_n), .brakeHigh(brakeHigh),
        .powerTakeoffActive(powerTakeoffActive), .tempOverLimit(cond[0]),
        .tempSensorFault(cond[1]), .netFanRequest(cond[6]), .roadSpeed(roadSpeed),
        .fanCtl1Open(fanCtl1Open), .fanCtl2Open(fanCtl2Open),
        .thirdSwitchedOutputOpen(thirdSwitchedOutputOpen)
    );

    task automatic results();
        if (fails == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic checkBit(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : checkBit

    task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord

    function automatic logic [31:0] cfgW(input logic [7:0] ty, input logic [7:0] sw,
                                         input logic [5:0] en, input logic [2:0] md);
        return {2'h0, en, 5'h00, md, sw, ty};
    endfunction : cfgW

    function automatic int maxOf(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : maxOf

    task automatic waitRdy();
        int j;
        j = 0;
        do begin
            @(posedge clk_sys);
            j++;
        end while (hreadyout !== 1'b1 && j < 16);
        if (hreadyout !== 1'b1) begin
            fails++;
            results();
        end
    endtask : waitRdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
    endtask : bus

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        checkWord("register", exp, rd);
        checkBit("hresp", 1'b0, hresp);
    endtask : rdChk

    // Sampled mid-cycle so the edge's own updates have landed
    task automatic fans(input logic e1, input logic e2);
        @(negedge clk_sys);
        checkBit("fan1", e1, fan1Spinning);
        checkBit("fan2", e2, fan2Spinning);
        checkBit("third", e1 & thirdOn, thirdSwitchedOutputOpen);
        @(posedge clk_sys);
    endtask : fans

    // Short demand, then the fan must outlast it by the hold time
    task automatic trial(input int c, input logic e1, input logic e2, input int holdS);
        cond[c] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        fans(e1, e2);
        cond[c] <= 1'b0;
        repeat ((holdS - 3) * TICK) @(posedge clk_sys);
        fans(e1, e2);
        repeat (5 * TICK) @(posedge clk_sys);
        fans(1'b0, 1'b0);
    endtask : trial

    initial begin
        void'($urandom(93));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        roadSpeed <= 8'($urandom_range(250));
        rdChk(ecf_pkg::REG_CFG_OFS, 32'h0402_00FF);
        rdChk(ecf_pkg::REG_SPEED_OFS, 32'h0000_0020);
        rdChk(ecf_pkg::REG_HOLD_OFS, 32'h00B4_000A);
        bus(1'b1, 8'h10, 32'hFFFF_FFFF);
        rdChk(8'h10, 32'h0000_0000);
        g = $urandom_range(40);
        h = maxOf(30, g);
        bus(1'b1, ecf_pkg::REG_HOLD_OFS, {16'h002D, 6'h00, 10'(g)});
        rdChk(ecf_pkg::REG_HOLD_OFS, {16'h002D, 6'h00, 10'(g)});
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b101110, 3'h2));
        rdChk(ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b101110, 3'h2));
        cond[0] <= 1'b1;
        engineOn <= 1'b1;
        repeat (35) @(posedge clk_sys);
        fans(1'b0, 1'b0);
        for (i = 0; i < 40 && fanCtl1Open !== 1'b1; i++) @(posedge clk_sys);
        if (fanCtl1Open !== 1'b1) begin
            fails++;
            results();
        end
        fans(1'b1, 1'b1);
        cond[0] <= 1'b0;
        repeat ((h + 5) * TICK) @(posedge clk_sys);
        fans(1'b0, 1'b0);
        k = $urandom_range(5);
        for (i = 0; i < 6; i++) begin
            n = (i + k) % 6;
            trial(n, 1'b1, n != 2, (n == 2) ? maxOf(h, 45) : h);
        end
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b000000, 3'h2));
        for (n = 2; n < 7; n++) begin
            if (n != 4) trial(n, 1'b0, 1'b0, h);
        end
        // Switching sense only while the input is ignored avoids a false request
        for (m = 0; m < 5; m++) begin
            bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b000100, 3'h0));
            acOpenWhenOn <= (m == 2 || m == 4);
            repeat (8) @(posedge clk_sys);
            bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b000100, 3'(m)));
            repeat (8) @(posedge clk_sys);
            trial(2, m == 1 || m == 2, 1'b0, (m == 1 || m == 2) ? maxOf(h, 45) : h);
        end
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b000101, 3'h2));
        thrA = $urandom_range(200);
        bus(1'b1, ecf_pkg::REG_SPEED_OFS, {24'h00_0000, 8'(thrA)});
        roadSpeed <= 8'(thrA);
        trial(2, 1'b1, 1'b0, maxOf(h, 45));
        roadSpeed <= 8'(thrA + 1);
        trial(2, 1'b1, 1'b0, h);
        thrF = $urandom_range(250, 1);
        bus(1'b1, ecf_pkg::REG_SPEED_OFS, {16'h0000, 8'(thrF), 8'(thrA)});
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h06, 8'h11, 6'b010100, 3'h2));
        roadSpeed <= 8'(thrF - 1);
        trial(0, 1'b0, 1'b0, h);
        roadSpeed <= 8'(thrF);
        trial(0, 1'b1, 1'b1, h);
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'h07, 8'h00, 6'b001100, 3'h2));
        thirdOn <= 1'b0;
        trial(6, 1'b1, 1'b0, h);
        trial(1, 1'b1, 1'b0, h);
        bus(1'b1, ecf_pkg::REG_CFG_OFS, cfgW(8'hFF, 8'h11, 6'b001100, 3'h2));
        thirdOn <= 1'b1;
        trial(0, 1'b0, 1'b0, h);
        rdChk(ecf_pkg::REG_STATUS_OFS, 32'h0000_02A0);
        results();
    end
endmodule : tb
`default_nettype wire
